// ### include/rshe_map.svh
/*
 * Constants of the rotate, subtract and halt execution block: opcodes, field bounds,
 * register offsets, reset values and status bit positions.
 * Assumes it is included by bare name from the package and the design files.
 */
`ifndef RSHE_MAP_SVH
`define RSHE_MAP_SVH

// Instruction word layout.
`define RSHE_IW_W            14
`define RSHE_FADDR_W         7
`define RSHE_FILE_DEPTH      128
`define RSHE_DEST_BIT        7
`define RSHE_OPC6_HI         13
`define RSHE_OPC6_LO         8
`define RSHE_OPC5_LO         9

// Opcode patterns.
`define RSHE_OPC_ROTL        6'h0D
`define RSHE_OPC_SUBF        6'h02
`define RSHE_OPC_SUBL        5'h1E
`define RSHE_OPC_HALT        14'h0063

// Register byte offsets on the plain register port.
`define RSHE_ADDR_W          10
`define RSHE_OFF_ACC         10'h000
`define RSHE_OFF_STATUS      10'h004
`define RSHE_OFF_CTRL        10'h008
`define RSHE_OFF_COUNT       10'h00C
`define RSHE_OFF_FILE        10'h200
`define RSHE_FILE_SEL_HI     9
`define RSHE_FILE_IDX_HI     8
`define RSHE_FILE_IDX_LO     2

// Status bit positions.
`define RSHE_ST_CARRY        0
`define RSHE_ST_NIBBLE       1
`define RSHE_ST_ZERO         2
`define RSHE_ST_SLEEP_N      3
`define RSHE_ST_EXPIRY_N     4
`define RSHE_ST_ASLEEP       5

// Control bit positions.
`define RSHE_CT_WAKE         0

// Reset values.
`define RSHE_RST_BYTE        8'h00
`define RSHE_RST_COUNT       16'h0000
`define RSHE_RST_RDATA       32'h0000_0000

`endif

// ### include/rshe_pkg.sv
/*
 * Types shared by the execution block and its arithmetic unit.
 * Assumes rshe_map.svh is on the include path.
 */
`include "rshe_map.svh"
`default_nettype none

package rshe_pkg;

	// Arithmetic flags kept by the core.
	typedef struct packed {
		logic carry;
		logic nibble;
		logic zero;
	} rshe_flags_t;

	// Decoded instruction kinds.
	typedef enum logic [2:0] {
		RSHE_OP_NONE,
		RSHE_OP_ROTL,
		RSHE_OP_SUBL,
		RSHE_OP_SUBF,
		RSHE_OP_HALT
	} rshe_op_t;

	// Everything one instruction produces in its cycle.
	typedef struct packed {
		rshe_op_t    op;
		logic [7:0]  result;
		rshe_flags_t flags;
		logic        wr_acc;
		logic        wr_file;
		logic        upd_carry;
		logic        upd_arith;
		logic        halt;
	} rshe_exec_t;

endpackage : rshe_pkg

`default_nettype wire

// ### src/rshe_alu.sv
/*
 * Decoder and arithmetic for the four instructions: rotate left through carry,
 * literal minus accumulator, file minus accumulator, and halt.
 * Assumes the file operand is already read out for the addressed location.
 */
`include "rshe_map.svh"
`default_nettype none

module rshe_alu (
	// Instruction and operands.
	input  wire logic [`RSHE_IW_W-1:0] instr,
	input  wire logic [7:0]            acc,
	input  wire logic [7:0]            file_val,
	input  wire logic                  carry_in,
	// Decoded result.
	output var rshe_pkg::rshe_exec_t   ex
);

	// Subtraction a - b by adding the complement; carry out means no borrow.
	function automatic logic [9:0] rshe_sub(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, a} + {1'b0, ~b} + 9'h001;
		low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
		return {full[8], low[4], full[7:0]};
	endfunction : rshe_sub

	logic [9:0] sub_r;
	logic [7:0] sub_a;

	// The subtrahend is always the accumulator; only the minuend differs.
	assign sub_a = (instr[`RSHE_OPC6_HI:`RSHE_OPC5_LO] == `RSHE_OPC_SUBL) ? instr[7:0] : file_val;
	assign sub_r = rshe_sub(sub_a, acc);

	// Decode and result select.
	always_comb begin
		ex           = '0;
		ex.op        = rshe_pkg::RSHE_OP_NONE;
		ex.flags     = '{carry: sub_r[9], nibble: sub_r[8], zero: (sub_r[7:0] == 8'h00)};
		ex.result    = sub_r[7:0];
		if (instr == `RSHE_OPC_HALT) begin
			ex.op   = rshe_pkg::RSHE_OP_HALT;
			ex.halt = 1'b1;
		end else if (instr[`RSHE_OPC6_HI:`RSHE_OPC6_LO] == `RSHE_OPC_ROTL) begin
			ex.op           = rshe_pkg::RSHE_OP_ROTL;
			ex.result       = {file_val[6:0], carry_in};
			ex.flags.carry  = file_val[7];
			ex.upd_carry    = 1'b1;
			ex.wr_file      = instr[`RSHE_DEST_BIT];
			ex.wr_acc       = ~instr[`RSHE_DEST_BIT];
		end else if (instr[`RSHE_OPC6_HI:`RSHE_OPC5_LO] == `RSHE_OPC_SUBL) begin
			ex.op        = rshe_pkg::RSHE_OP_SUBL;
			ex.wr_acc    = 1'b1;
			ex.upd_carry = 1'b1;
			ex.upd_arith = 1'b1;
		end else if (instr[`RSHE_OPC6_HI:`RSHE_OPC6_LO] == `RSHE_OPC_SUBF) begin
			ex.op        = rshe_pkg::RSHE_OP_SUBF;
			ex.wr_file   = instr[`RSHE_DEST_BIT];
			ex.wr_acc    = ~instr[`RSHE_DEST_BIT];
			ex.upd_carry = 1'b1;
			ex.upd_arith = 1'b1;
		end
	end

endmodule : rshe_alu

`default_nettype wire

// ### src/rshe_exec.sv
/*
 * Execution block for rotate left through carry, the two subtract forms and
 * halt, with accumulator, 128-entry file, status flags and a register port.
 * Assumes program memory presents one instruction word per cycle with a valid
 * strobe on core_clk, and that the watchdog logic acts on the clear pulses.
 */
`include "rshe_map.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rshe_exec #(
	parameter int FILE_DEPTH = `RSHE_FILE_DEPTH,
	parameter int COUNT_W    = 16
) (
	// Clock and reset.
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	// Instruction stream from program memory.
	input  wire logic                    instr_valid,
	input  wire logic [`RSHE_IW_W-1:0]   instr_word,
	output logic                         instr_ready,
	// Wake request pin from the outside.
	input  wire logic                    wake_pin,
	// Watchdog and power control.
	output logic                         watchdog_counter_clr,
	output logic                         prescaler_clr,
	output logic                         osc_stop,
	output logic                         sleep_entered_n,
	output logic                         expiry_flag_n,
	// Register port.
	input  wire logic [`RSHE_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [31:0]                  reg_rdata
);

	////////////////////////////////////////////////////////////////////////////
	// State.

	// Datapath registers.
	logic [7:0]           acc_q;
	logic [7:0]           file_q [FILE_DEPTH];
	rshe_pkg::rshe_flags_t flags_q;
	logic                 sleep_n_q;
	logic                 expiry_n_q;
	logic                 asleep_q;
	logic                 wd_clr_q;
	logic [COUNT_W-1:0]   count_q;
	logic [31:0]          rdata_q;
	logic                 wake_s1_q;
	logic                 wake_s2_q;
	logic                 wake_s3_q;

	// Combinational decode and bus signals.
	rshe_pkg::rshe_exec_t ex;
	logic [`RSHE_FADDR_W-1:0] faddr;
	logic                 exec_go;
	logic                 wake_rise;
	logic                 sw_wake;
	logic                 bus_file;
	logic [`RSHE_FADDR_W-1:0] bus_idx;
	logic                 acc_wr_hit;
	logic                 status_wr_hit;
	logic                 ctrl_wr_hit;
	logic                 count_wr_hit;
	logic                 wake_req;

	////////////////////////////////////////////////////////////////////////////
	// Decode and arithmetic.

	assign faddr = instr_word[`RSHE_FADDR_W-1:0];

	assign exec_go     = instr_valid & ~asleep_q;
	assign instr_ready = ~asleep_q;

	// The operand is read from the file in the same cycle, so one cycle covers read, modify and write.
	rshe_alu u_alu (
		.instr    (instr_word),
		.acc      (acc_q),
		.file_val (file_q[faddr]),
		.carry_in (flags_q.carry),
		.ex       (ex)
	);

	////////////////////////////////////////////////////////////////////////////
	// Wake request synchroniser and bus decode.

	// The pin is asynchronous; the second and third stages feed the edge detector, never the first.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_s1_q <= 1'b0;
			wake_s2_q <= 1'b0;
			wake_s3_q <= 1'b0;
		end else begin
			wake_s1_q <= wake_pin;
			wake_s2_q <= wake_s1_q;
			wake_s3_q <= wake_s2_q;
		end
	end

	// Of the pin, only a rising edge wakes the core, so a pin held high cannot undo the next halt.
	assign wake_rise = wake_s2_q & ~wake_s3_q;

	// Register-port write decode, shared by every writable register below except the file.
	function automatic logic rshe_wr_hit(
		input logic                    wr,
		input logic [`RSHE_ADDR_W-1:0] addr,
		input logic [`RSHE_ADDR_W-1:0] off
	);
		return wr && (addr == off);
	endfunction : rshe_wr_hit

	// Decoded write strobes; the file window is selected by one address bit instead.
	assign acc_wr_hit    = rshe_wr_hit(reg_wr, reg_addr, `RSHE_OFF_ACC);
	assign status_wr_hit = rshe_wr_hit(reg_wr, reg_addr, `RSHE_OFF_STATUS);
	assign ctrl_wr_hit   = rshe_wr_hit(reg_wr, reg_addr, `RSHE_OFF_CTRL);
	assign count_wr_hit  = rshe_wr_hit(reg_wr, reg_addr, `RSHE_OFF_COUNT);
	assign sw_wake       = ctrl_wr_hit & reg_wdata[`RSHE_CT_WAKE];
	assign bus_file      = reg_addr[`RSHE_FILE_SEL_HI];
	assign bus_idx       = reg_addr[`RSHE_FILE_IDX_HI:`RSHE_FILE_IDX_LO];

	// Either wake source ends the low-power state; halt still wins a tie.
	assign wake_req = wake_rise | sw_wake;

	////////////////////////////////////////////////////////////////////////////
	// Accumulator.

	// An executing instruction beats a software write in the same cycle.
	// Software may still preload the accumulator while the core sleeps.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_q <= `RSHE_RST_BYTE;
		end else if (exec_go && ex.wr_acc) begin
			acc_q <= ex.result;
		end else if (acc_wr_hit) begin
			acc_q <= reg_wdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// File registers.

	// One write port; the instruction write-back takes priority over software.
	// Every location is cleared at reset so reads of unwritten locations are defined.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < FILE_DEPTH; i++) begin
				file_q[i] <= `RSHE_RST_BYTE;
			end
		end else if (exec_go && ex.wr_file) begin
			file_q[faddr] <= ex.result;
		end else if (reg_wr && bus_file) begin
			file_q[bus_idx] <= reg_wdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Arithmetic flags.

	// Hardware updates win over a software write of the status word.
	// A rotate touches only the carry; zero and nibble keep their last subtract.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= '0;
		end else if (exec_go && (ex.upd_carry || ex.upd_arith)) begin
			if (ex.upd_carry) begin
				flags_q.carry <= ex.flags.carry;
			end
			if (ex.upd_arith) begin
				flags_q.nibble <= ex.flags.nibble;
				flags_q.zero   <= ex.flags.zero;
			end
		end else if (status_wr_hit) begin
			flags_q.carry  <= reg_wdata[`RSHE_ST_CARRY];
			flags_q.nibble <= reg_wdata[`RSHE_ST_NIBBLE];
			flags_q.zero   <= reg_wdata[`RSHE_ST_ZERO];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power status and halt.

	// The power flags are only changed by halt here; reset sets both high.
	// Waking does not restore the sleep flag, so software can tell that the core has slept.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_n_q  <= 1'b1;
			expiry_n_q <= 1'b1;
		end else if (exec_go && ex.halt) begin
			sleep_n_q  <= 1'b0;
			expiry_n_q <= 1'b1;
		end
	end

	// Halt entry wins over a wake request arriving in the same cycle.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			asleep_q <= 1'b0;
		end else if (exec_go && ex.halt) begin
			asleep_q <= 1'b1;
		end else if (wake_req) begin
			asleep_q <= 1'b0;
		end
	end

	// One-cycle clear pulse to the watchdog count and its prescaler.
	// Registered so the pulse is glitch-free at the watchdog, at the cost of one cycle.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wd_clr_q <= 1'b0;
		end else begin
			wd_clr_q <= exec_go & ex.halt;
		end
	end

	// Status and control pins come straight from their registers.
	assign watchdog_counter_clr = wd_clr_q;
	assign prescaler_clr        = wd_clr_q;
	assign osc_stop             = asleep_q;
	assign sleep_entered_n      = sleep_n_q;
	assign expiry_flag_n        = expiry_n_q;

	////////////////////////////////////////////////////////////////////////////
	// Executed-instruction counter.

	// Counts decoded instructions only; wraps silently at full scale.
	// A software write wins, so the count can be zeroed without stopping the core.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= COUNT_W'(`RSHE_RST_COUNT);
		end else if (count_wr_hit) begin
			count_q <= reg_wdata[COUNT_W-1:0];
		end else if (exec_go && ex.op != rshe_pkg::RSHE_OP_NONE) begin
			count_q <= count_q + COUNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the read strobe; unmapped addresses read zero.
	// Zero outside the answer cycle lets several slaves share one read bus by OR.

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= `RSHE_RST_RDATA;
		end else if (reg_rd) begin
			rdata_q <= `RSHE_RST_RDATA;
			if (bus_file) begin
				rdata_q[7:0] <= file_q[bus_idx];
			end else begin
				unique case (reg_addr)
					`RSHE_OFF_ACC: begin
						rdata_q[7:0] <= acc_q;
					end
					`RSHE_OFF_STATUS: begin
						rdata_q[`RSHE_ST_CARRY]    <= flags_q.carry;
						rdata_q[`RSHE_ST_NIBBLE]   <= flags_q.nibble;
						rdata_q[`RSHE_ST_ZERO]     <= flags_q.zero;
						rdata_q[`RSHE_ST_SLEEP_N]  <= sleep_n_q;
						rdata_q[`RSHE_ST_EXPIRY_N] <= expiry_n_q;
						rdata_q[`RSHE_ST_ASLEEP]   <= asleep_q;
					end
					`RSHE_OFF_COUNT: begin
						rdata_q[COUNT_W-1:0] <= count_q;
					end
					default: begin
						rdata_q <= `RSHE_RST_RDATA;
					end
				endcase
			end
		end else begin
			rdata_q <= `RSHE_RST_RDATA;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : rshe_exec

`default_nettype wire

// ### verif/rshe_exec_asserts.sv
/* Checker for halt, power flags and instruction pacing of rshe_exec.
   Assumes it is bound to rshe_exec and sees its ports only. */
`include "rshe_map.svh"
`default_nettype none
module rshe_exec_asserts (
	// Clock and reset.
	input wire logic                  core_clk,
	input wire logic                  arst_n,
	// Instruction stream.
	input wire logic                  instr_valid,
	input wire logic [`RSHE_IW_W-1:0] instr_word,
	input wire logic                  instr_ready,
	// Power and watchdog control.
	input wire logic                  watchdog_counter_clr,
	input wire logic                  prescaler_clr,
	input wire logic                  osc_stop,
	input wire logic                  sleep_entered_n,
	input wire logic                  expiry_flag_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic take_halt;
	logic take_other;

	// Taken words, split so every check names its own cause.
	assign take_halt  = instr_valid && instr_ready && instr_word == `RSHE_OPC_HALT;
	assign take_other = instr_valid && instr_ready && instr_word != `RSHE_OPC_HALT;

	////////////////////////////////////////
	halt_clear_a: assert property (take_halt |=> watchdog_counter_clr)
		else $error("watchdog clear missing after halt");
	clr_pair_a: assert property (watchdog_counter_clr == prescaler_clr)
		else $error("prescaler clear differs from watchdog clear");
	clear_cause_a: assert property (watchdog_counter_clr |-> $past(take_halt))
		else $error("watchdog clear without a halt");
	halt_flags_a: assert property (take_halt |=> !sleep_entered_n && expiry_flag_n)
		else $error("power flags wrong after halt");
	flag_cause_a: assert property ($fell(sleep_entered_n) |-> $past(take_halt))
		else $error("sleep flag fell without a halt");
	halt_stop_a: assert property (take_halt |=> osc_stop && !instr_ready)
		else $error("core still running after halt");
	asleep_ready_a: assert property (osc_stop |-> !instr_ready)
		else $error("ready while oscillator stopped");
	one_cycle_a: assert property (take_other |=> instr_ready && !watchdog_counter_clr)
		else $error("ordinary word stalled or cleared watchdog");

	// Main scenarios reached.
	cover property (take_halt);
	cover property ($rose(instr_ready));
	cover property (take_other ##1 take_other);
endmodule : rshe_exec_asserts

bind rshe_exec rshe_exec_asserts u_chk (.core_clk(core_clk), .arst_n(arst_n), .instr_valid(instr_valid),
	.instr_word(instr_word), .instr_ready(instr_ready), .watchdog_counter_clr(watchdog_counter_clr),
	.prescaler_clr(prescaler_clr), .osc_stop(osc_stop), .sleep_entered_n(sleep_entered_n),
	.expiry_flag_n(expiry_flag_n));
`default_nettype wire

// ### verif/rshe_prog_mem.sv
/* Program memory model offering queued instruction words one at a time.
   Assumes the bench pushes words between clock edges. */
`include "rshe_map.svh"
`default_nettype none
module rshe_prog_mem (
	// Clock and reset.
	input  wire logic                  core_clk,
	input  wire logic                  arst_n,
	// Handshake; slow adds an idle cycle before each word.
	input  wire logic                  instr_ready,
	input  wire logic                  slow,
	output logic                       instr_valid,
	output logic [`RSHE_IW_W-1:0]      instr_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [`RSHE_IW_W-1:0] q [$];
	logic                  idle_q;

	// Queue one word.
	task automatic push(input logic [`RSHE_IW_W-1:0] w);
		q.push_back(w);
	endtask : push

	// A word is held until taken; an empty slot toggles so a stale word never looks current.
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			instr_valid <= 1'b0;
			instr_word  <= 14'h0000;
			idle_q      <= 1'b0;
		end else if (!instr_valid || instr_ready) begin
			if (instr_valid)
				void'(q.pop_front());
			idle_q <= slow && !idle_q;
			if (q.size() != 0 && !(slow && !idle_q)) begin
				instr_valid <= 1'b1;
				instr_word  <= q[0];
			end else begin
				instr_valid <= 1'b0;
				instr_word  <= ~instr_word;
			end
		end
	end
endmodule : rshe_prog_mem
`default_nettype wire

// ### verif/rshe_exec_bench.sv
/* Self-checking bench for rshe_exec with a program memory model.
   Assumes the checker and model files are compiled first. */
`include "rshe_map.svh"
`default_nettype none
module rshe_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, arst_n, wake_pin, slow, instr_valid, instr_ready;
	logic        watchdog_counter_clr, prescaler_clr, osc_stop, sleep_entered_n, expiry_flag_n;
	logic [13:0] instr_word;
	logic [9:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd;
	int          mismatches = 0;
	int          checks = 0;

	rshe_exec dut (.core_clk(core_clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
		.instr_ready(instr_ready), .wake_pin(wake_pin), .watchdog_counter_clr(watchdog_counter_clr),
		.prescaler_clr(prescaler_clr), .osc_stop(osc_stop), .sleep_entered_n(sleep_entered_n),
		.expiry_flag_n(expiry_flag_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	rshe_prog_mem prog (.core_clk(core_clk), .arst_n(arst_n), .instr_ready(instr_ready), .slow(slow),
		.instr_valid(instr_valid), .instr_word(instr_word));

	////////////////////////////////////////
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// Bus write; the strobe drops a cycle before any next access.
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Bus read; data stand only in the cycle after the strobe.
	task automatic rd(input string what, input logic [9:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 cmp(what, exp, reg_rdata);
	endtask : rd

	// Hand one word to memory and wait, bounded, until the core took it.
	task automatic run(input logic [13:0] w);
		@(negedge core_clk);
		prog.push(w);
		for (int i = 0; i < 40 && prog.q.size() != 0; i++)
			@(posedge core_clk);
	endtask : run

	task automatic t_rotate;
		wr(`RSHE_OFF_FILE + 10'h014, 32'hE6);
		wr(`RSHE_OFF_STATUS, 32'h0);
		run(14'h0D05);
		rd("rot acc", `RSHE_OFF_ACC, 32'hCC);
		rd("rot carry", `RSHE_OFF_STATUS, 32'h19);
		wr(`RSHE_OFF_FILE + 10'h1FC, 32'h81);
		run(14'h0DFF);
		rd("rot file", `RSHE_OFF_FILE + 10'h1FC, 32'h03);
		rd("rot keep", `RSHE_OFF_ACC, 32'hCC);
	endtask : t_rotate

	// Both encodings of the ignored bit, positive, zero, negative and nibble borrow.
	task automatic t_sub_lit;
		logic [7:0] k [4] = '{8'h02, 8'h02, 8'h02, 8'h10};
		logic [7:0] w [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
		logic [7:0] r;
		for (int i = 0; i < 4; i++) begin
			r = k[i] - w[i];
			wr(`RSHE_OFF_ACC, {24'h0, w[i]});
			run({5'h1E, i[0], k[i]});
			rd("subl acc", `RSHE_OFF_ACC, {24'h0, r});
			rd("subl flags", `RSHE_OFF_STATUS, {27'h0, 2'h3, r == 8'h0, k[i][3:0] >= w[i][3:0], k[i] >= w[i]});
		end
	endtask : t_sub_lit

	// Slow memory: file minus accumulator to both destinations.
	task automatic t_sub_file;
		slow <= 1'b1;
		wr(`RSHE_OFF_ACC, 32'h2);
		wr(`RSHE_OFF_FILE + 10'h100, 32'h1);
		run(14'h02C0);
		rd("subf file", `RSHE_OFF_FILE + 10'h100, 32'hFF);
		rd("subf acc", `RSHE_OFF_ACC, 32'h2);
		rd("subf flags", `RSHE_OFF_STATUS, 32'h18);
		wr(`RSHE_OFF_FILE + 10'h00C, 32'h3);
		run(14'h0203);
		rd("subf acc d0", `RSHE_OFF_ACC, 32'h1);
		rd("subf file d0", `RSHE_OFF_FILE + 10'h00C, 32'h3);
		slow <= 1'b0;
	endtask : t_sub_file

	// Two words back to back, each in one cycle.
	task automatic t_burst;
		wr(`RSHE_OFF_ACC, 32'h5);
		@(negedge core_clk);
		prog.push(14'h3C09);
		run(14'h3C0A);
		rd("burst acc", `RSHE_OFF_ACC, 32'h6);
	endtask : t_burst

	// Halt, a word held while asleep and run after the pin wake, then register wake.
	task automatic t_halt;
		run(14'h0062);
		run(`RSHE_OPC_HALT);
		#1 cmp("power flags", 32'h1, {30'h0, sleep_entered_n, expiry_flag_n});
		cmp("osc stop", 32'h1, {31'h0, osc_stop});
		wr(`RSHE_OFF_ACC, 32'h7);
		@(negedge core_clk);
		prog.push(14'h3C09);
		repeat (6) @(posedge core_clk);
		rd("asleep acc", `RSHE_OFF_ACC, 32'h7);
		@(posedge core_clk);
		wake_pin <= 1'b1;
		for (int i = 0; i < 20 && prog.q.size() != 0; i++)
			@(posedge core_clk);
		wake_pin <= 1'b0;
		rd("woken acc", `RSHE_OFF_ACC, 32'h2);
		run(`RSHE_OPC_HALT);
		wr(`RSHE_OFF_CTRL, 32'h1);
		rd("wake status", `RSHE_OFF_STATUS, 32'h13);
		rd("exec count", `RSHE_OFF_COUNT, 32'hD);
		rd("unmapped", 10'h100, 32'h0);
	endtask : t_halt

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// Clock of 8 ns.
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Main sequence after ten cycles of reset.
	initial begin
		arst_n    = 1'b0;
		wake_pin  = 1'b0;
		slow      = 1'b0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 10'h000;
		reg_wdata = 32'h0;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		rd("reset status", `RSHE_OFF_STATUS, 32'h18);
		t_rotate;
		t_sub_lit;
		t_sub_file;
		t_burst;
		t_halt;
		conclude;
	end

	// The run needs well under a thousand cycles; a hang ends here.
	initial begin
		repeat (3000) @(posedge core_clk);
		mismatches++;
		conclude;
	end
endmodule : rshe_exec_bench
`default_nettype wire
